// ==== exec_pkg.sv ====
package exec_pkg;
  // instruction word: [15:10] op, [9:5] destination, [4:0] aux field
  localparam int INSTR_W = 16;
  localparam int OP_MSB  = 15;
  localparam int OP_LSB  = 10;
  localparam int RD_MSB  = 9;
  localparam int RD_LSB  = 5;
  localparam int AX_MSB  = 4;

  localparam logic [5:0] OP_NOP            = 6'h00;
  localparam logic [5:0] OP_BR_OVF_SET     = 6'h01;
  localparam logic [5:0] OP_BR_OVF_CLR     = 6'h02;
  localparam logic [5:0] OP_BR_IRQ_ON      = 6'h03;
  localparam logic [5:0] OP_BR_IRQ_OFF     = 6'h04;
  localparam logic [5:0] OP_COPY_REG       = 6'h05;
  localparam logic [5:0] OP_COPY_PAIR      = 6'h06;
  localparam logic [5:0] OP_LOAD_IMM       = 6'h07;
  localparam logic [5:0] OP_LOAD_DIRECT    = 6'h08;
  localparam logic [5:0] OP_LOAD_PTR       = 6'h09;
  localparam logic [5:0] OP_LOAD_DISPLACED = 6'h0A;
  localparam logic [5:0] OP_STORE_DIRECT   = 6'h0B;
  localparam logic [5:0] OP_STORE_PTR      = 6'h0C;
  localparam logic [5:0] OP_STORE_DISPL    = 6'h0D;
  localparam logic [5:0] OP_PMEM_LOAD      = 6'h0E;
  localparam logic [5:0] OP_IO_IN          = 6'h0F;
  localparam logic [5:0] OP_IO_OUT         = 6'h10;
  localparam logic [5:0] OP_PUSH           = 6'h11;
  localparam logic [5:0] OP_POP            = 6'h12;
  localparam logic [5:0] OP_SHIFT_LEFT     = 6'h13;
  localparam logic [5:0] OP_ROTATE_LEFT    = 6'h14;
  localparam logic [5:0] OP_SHIFT_RIGHT    = 6'h15;
  localparam logic [5:0] OP_ROTATE_RIGHT   = 6'h16;
  localparam logic [5:0] OP_SHIFT_R_ARITH  = 6'h17;
  localparam logic [5:0] OP_SWAP_NIBBLES   = 6'h18;
  localparam logic [5:0] OP_IO_BIT_SET     = 6'h19;
  localparam logic [5:0] OP_IO_BIT_CLEAR   = 6'h1A;
  localparam logic [5:0] OP_BIT_TO_T       = 6'h1B;
  localparam logic [5:0] OP_T_TO_BIT       = 6'h1C;
  localparam logic [5:0] OP_FLAG_SET       = 6'h1D;
  localparam logic [5:0] OP_FLAG_CLEAR     = 6'h1E;

  // pointer modes in aux[4:3], pointer select in aux[1:0]
  localparam logic [1:0] PM_PLAIN   = 2'h0;
  localparam logic [1:0] PM_POSTINC = 2'h1;
  localparam logic [1:0] PM_PREDEC  = 2'h2;
  localparam logic [1:0] PTR_X      = 2'h0;
  localparam logic [1:0] PTR_Y      = 2'h1;
  localparam logic [4:0] BASE_X     = 5'h1A;
  localparam logic [4:0] BASE_Y     = 5'h1C;
  localparam logic [4:0] BASE_Z     = 5'h1E;
  // program memory load forms in aux[1:0]
  localparam logic [1:0] PL_R0      = 2'h0;
  localparam logic [1:0] PL_POSTINC = 2'h2;

  // status flag bit positions
  localparam int FL_C = 0;
  localparam int FL_Z = 1;
  localparam int FL_N = 2;
  localparam int FL_V = 3;
  localparam int FL_S = 4;
  localparam int FL_H = 5;
  localparam int FL_T = 6;
  localparam int FL_I = 7;

  localparam logic [1:0] CYC_ONE   = 2'h1;
  localparam logic [1:0] CYC_TWO   = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;

  // data addresses at or above this go through the slow memory controller
  localparam logic [15:0] NVM_BASE = 16'h8000;

  localparam logic [15:0] SP_RESET    = 16'h0FFF;
  localparam logic [15:0] PC_RESET    = 16'h0000;
  localparam logic [7:0]  FLAGS_RESET = 8'h00;

  // register bus
  localparam int          AVS_AW       = 5;
  localparam logic [2:0]  REG_CTRL     = 3'h0;
  localparam logic [2:0]  REG_FLAGS    = 3'h1;
  localparam logic [2:0]  REG_PC       = 3'h2;
  localparam logic [2:0]  REG_SP       = 3'h3;
  localparam logic [2:0]  REG_STATE    = 3'h4;
  localparam int          CTRL_RUN_BIT = 0;
endpackage : exec_pkg

// ==== core_instruction_subset_exec.sv ====
`timescale 1ns/1ps
// Operation
// - branch on overflow set or clear to pc+k+1, one or two cycles, no flags.
// - branch on global irq flag set or clear, pc+k+1, one or two cycles.
// - direct load copies byte at 16-bit address into register, three cycles.
// - pointer load with post-increment reads then increments pointer, two cycles.
// - pointer load with pre-decrement decrements pointer then reads, two cycles.
// - displaced load reads Y or Z plus q, pointer unchanged, two cycles.
// - direct store writes register to 16-bit address in two cycles.
// - pointer store with post-increment writes then increments, one cycle.
// - pointer store with pre-decrement decrements then writes, one cycle.
// - displaced store writes to Y or Z plus q, pointer unchanged, one cycle.
// - program memory load via Z into R0 or register, three cycles, optional Z+1.
// - io in and io out copy one byte in one cycle, no flags.
// - push takes one cycle, pop takes two, no flags.
// - left shift and rotate send bit 7 to carry, update Z,C,N,V,H.
// - right rotate, shift, arith shift send bit 0 to carry, update Z,C,N,V.
// - io bit set and clear force one bit of an io location, one cycle.
// - bit store copies a register bit into T, only T changes.
// - bit load copies T into a register bit, no flag change.
// - flag set and clear touch only the addressed status bit, one cycle.
// - slow memory controller accesses take at least one extra cycle.
module core_instruction_subset_exec
(
  // clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          rstn,
  // instruction feed
  input  wire logic                          instr_valid,
  input  wire logic [exec_pkg::INSTR_W-1:0]  instr_word,
  input  wire logic [15:0]                   instr_imm,
  output logic                               instr_ready,
  output logic [15:0]                        pc,
  // data memory
  output logic [15:0]                        dmem_addr,
  output logic [7:0]                         dmem_wdata,
  output logic                               dmem_re,
  output logic                               dmem_we,
  input  wire logic [7:0]                    dmem_rdata,
  input  wire logic                          dmem_wait,
  // program memory
  output logic [15:0]                        pmem_addr,
  output logic                               pmem_re,
  input  wire logic [7:0]                    pmem_rdata,
  // io space
  output logic [5:0]                         io_addr,
  output logic                               io_re,
  output logic                               io_we,
  output logic [7:0]                         io_wdata,
  input  wire logic [7:0]                    io_rdata,
  // register bus
  input  wire logic [exec_pkg::AVS_AW-1:0]   avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [31:0]                   avs_writedata,
  input  wire logic [3:0]                    avs_byteenable,
  output logic [31:0]                        avs_readdata,
  output logic                               avs_waitrequest
);
  import exec_pkg::*;

  typedef enum logic {PH_IDLE, PH_RUN} phase_t;

  function automatic logic [1:0] cycles(input logic [5:0] o,
                                        input logic tk);
    case (o)
      OP_LOAD_DIRECT, OP_PMEM_LOAD:  cycles = CYC_THREE;
      OP_LOAD_PTR, OP_LOAD_DISPLACED,
      OP_STORE_DIRECT, OP_POP:       cycles = CYC_TWO;
      OP_BR_OVF_SET, OP_BR_OVF_CLR,
      OP_BR_IRQ_ON, OP_BR_IRQ_OFF:   cycles = tk ? CYC_TWO : CYC_ONE;
      default:                       cycles = CYC_ONE;
    endcase
  endfunction : cycles

  function automatic logic [4:0] ptr_base(input logic [1:0] sel);
    case (sel)
      PTR_X:   ptr_base = BASE_X;
      PTR_Y:   ptr_base = BASE_Y;
      default: ptr_base = BASE_Z;
    endcase
  endfunction : ptr_base

  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    for (int i = 0; i < 4; i++)
      be_merge[i*8 +: 8] = be[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
  endfunction : be_merge

  logic [7:0]   regs_r [32];
  logic [7:0]   status_flags_r;
  logic [15:0]  pc_r;
  logic [15:0]  sp_r;
  logic         run_r;
  phase_t       phase_r;
  logic [1:0]   step_r;
  logic [15:0]  ir_r;
  logic [15:0]  imm_r;
  logic         nvm_seen_r;
  logic         ack_r;
  logic [31:0]  avs_readdata_r;

  logic         busy, go, taken, last, adv, fin, stall, nvm, hold_strobe;
  logic         is_load, is_store, acc;
  logic [15:0]  cur, immv, ptrv, zv;
  logic [5:0]   op;
  logic [4:0]   rd, ax, pb, pnx;
  logic [2:0]   bsel;
  logic [1:0]   stp, tot, pmode;
  logic [7:0]   rdv, rrv, sh_res;
  logic         sh_c;
  logic         wr_en, pw_en, fl_we, sp_we;
  logic [4:0]   wr_idx;
  logic [3:0]   pw_idx;
  logic [7:0]   wr_dat, fl;
  logic [15:0]  pw_dat, sp_nxt;
  logic         av_req, av_ack;
  logic [31:0]  fl_wv, pc_wv, sp_wv;

  assign busy  = (phase_r == PH_RUN);
  assign cur   = busy ? ir_r : instr_word;
  assign immv  = busy ? imm_r : instr_imm;
  assign go    = busy | (instr_valid & run_r);
  assign stp   = busy ? step_r : 2'h0;
  assign op    = cur[OP_MSB:OP_LSB];
  assign rd    = cur[RD_MSB:RD_LSB];
  assign ax    = cur[AX_MSB:0];
  assign bsel  = ax[2:0];
  assign pmode = ax[4:3];
  assign rdv   = regs_r[rd];
  assign rrv   = regs_r[ax];
  assign pb    = ptr_base(ax[1:0]);
  assign pnx   = pb + 5'h01;
  assign ptrv  = {regs_r[pnx], regs_r[pb]};
  assign zv    = {regs_r[BASE_Z + 5'h01], regs_r[BASE_Z]};

  assign taken = (op == OP_BR_OVF_SET &  status_flags_r[FL_V])
               | (op == OP_BR_OVF_CLR & ~status_flags_r[FL_V])
               | (op == OP_BR_IRQ_ON  &  status_flags_r[FL_I])
               | (op == OP_BR_IRQ_OFF & ~status_flags_r[FL_I]);
  assign tot   = cycles(op, taken);
  assign last  = (stp == tot - 2'h1);

  assign is_load  = (op == OP_LOAD_DIRECT) | (op == OP_LOAD_PTR)
                  | (op == OP_LOAD_DISPLACED) | (op == OP_POP);
  assign is_store = (op == OP_STORE_DIRECT) | (op == OP_STORE_PTR)
                  | (op == OP_STORE_DISPL) | (op == OP_PUSH);
  // every data access happens in the instruction's last cycle
  assign acc      = go & last & (is_load | is_store);

  always_comb
  begin
    case (op)
      OP_LOAD_DIRECT, OP_STORE_DIRECT:  dmem_addr = immv;
      OP_LOAD_DISPLACED, OP_STORE_DISPL:
        dmem_addr = ptrv + {10'h0, immv[5:0]};
      OP_STORE_PTR:
        dmem_addr = (pmode == PM_PREDEC) ? ptrv - 16'h0001
                                         : ptrv;
      OP_PUSH, OP_POP:                  dmem_addr = sp_r;
      default:                          dmem_addr = ptrv;
    endcase
  end

  // first slow cycle carries no strobe so the access cannot land early
  assign nvm         = dmem_addr >= NVM_BASE;
  assign hold_strobe = nvm & ~nvm_seen_r;
  assign stall       = acc & nvm & (~nvm_seen_r | dmem_wait);
  assign dmem_re     = acc & is_load & ~hold_strobe;
  assign dmem_we     = acc & is_store & ~hold_strobe;
  assign dmem_wdata  = rrv;
  assign adv         = go & ~stall;
  assign fin         = adv & last;
  assign instr_ready = run_r & ~busy;
  assign pc          = pc_r;

  assign pmem_addr = zv;
  assign pmem_re   = go & last & (op == OP_PMEM_LOAD);
  assign io_addr   = immv[5:0];
  assign io_re     = go & ((op == OP_IO_IN) | (op == OP_IO_BIT_SET)
                         | (op == OP_IO_BIT_CLEAR));
  assign io_we     = go & ((op == OP_IO_OUT) | (op == OP_IO_BIT_SET)
                         | (op == OP_IO_BIT_CLEAR));

  always_comb
  begin
    case (op)
      OP_IO_BIT_SET:   io_wdata = io_rdata | (8'h01 << bsel);
      OP_IO_BIT_CLEAR: io_wdata = io_rdata & ~(8'h01 << bsel);
      default:         io_wdata = rdv;
    endcase
  end

  always_comb
  begin
    sh_c = rdv[0];
    case (op)
      OP_SHIFT_LEFT:  begin sh_res = {rdv[6:0], 1'b0}; sh_c = rdv[7]; end
      OP_ROTATE_LEFT:
      begin
        sh_res = {rdv[6:0], status_flags_r[FL_C]};
        sh_c   = rdv[7];
      end
      OP_SHIFT_RIGHT:   sh_res = {1'b0, rdv[7:1]};
      OP_ROTATE_RIGHT:  sh_res = {status_flags_r[FL_C], rdv[7:1]};
      default:          sh_res = {rdv[7], rdv[7:1]};
    endcase
  end

  always_comb
  begin
    wr_en  = 1'b0;
    wr_idx = rd;
    wr_dat = 8'h00;
    pw_en  = 1'b0;
    pw_idx = pb[4:1];
    pw_dat = ptrv;
    fl_we  = 1'b0;
    fl     = status_flags_r;
    sp_we  = 1'b0;
    sp_nxt = sp_r;
    case (op)
      OP_COPY_REG:   begin wr_en = 1'b1; wr_dat = rrv; end
      OP_COPY_PAIR:
      begin
        pw_en  = 1'b1;
        pw_idx = rd[4:1];
        pw_dat = {regs_r[{ax[4:1], 1'b1}], regs_r[{ax[4:1], 1'b0}]};
      end
      OP_LOAD_IMM:   begin wr_en = 1'b1; wr_dat = immv[7:0]; end
      OP_LOAD_DIRECT, OP_LOAD_DISPLACED:
      begin
        wr_en  = fin;
        wr_dat = dmem_rdata;
      end
      OP_LOAD_PTR:
      begin
        wr_en  = fin;
        wr_dat = dmem_rdata;
        pw_en  = (stp == 2'h0 & pmode == PM_PREDEC)
               | (fin & pmode == PM_POSTINC);
        pw_dat = (pmode == PM_PREDEC) ? ptrv - 16'h0001 : ptrv + 16'h0001;
      end
      OP_STORE_PTR:
      begin
        pw_en  = pmode != PM_PLAIN;
        pw_dat = (pmode == PM_PREDEC) ? ptrv - 16'h0001 : ptrv + 16'h0001;
      end
      OP_PMEM_LOAD:
      begin
        wr_en  = fin;
        wr_idx = (ax[1:0] == PL_R0) ? 5'h00 : rd;
        wr_dat = pmem_rdata;
        pw_en  = fin & (ax[1:0] == PL_POSTINC);
        pw_idx = BASE_Z[4:1];
        pw_dat = zv + 16'h0001;
      end
      OP_IO_IN:      begin wr_en = 1'b1; wr_dat = io_rdata; end
      OP_PUSH:       begin sp_we = 1'b1; sp_nxt = sp_r - 16'h0001; end
      OP_POP:
      begin
        sp_we  = (stp == 2'h0);
        sp_nxt = sp_r + 16'h0001;
        wr_en  = fin;
        wr_dat = dmem_rdata;
      end
      OP_SHIFT_LEFT, OP_ROTATE_LEFT, OP_SHIFT_RIGHT, OP_ROTATE_RIGHT,
      OP_SHIFT_R_ARITH:
      begin
        wr_en     = 1'b1;
        wr_dat    = sh_res;
        fl_we     = 1'b1;
        fl[FL_C]  = sh_c;
        fl[FL_Z]  = (sh_res == 8'h00);
        fl[FL_N]  = sh_res[7];
        fl[FL_V]  = sh_res[7] ^ sh_c;
        if (op == OP_SHIFT_LEFT || op == OP_ROTATE_LEFT)
          fl[FL_H] = rdv[3];
      end
      OP_SWAP_NIBBLES: begin wr_en = 1'b1; wr_dat = {rdv[3:0], rdv[7:4]}; end
      OP_BIT_TO_T:   begin fl_we = 1'b1; fl[FL_T] = rrv[bsel]; end
      OP_T_TO_BIT:
      begin
        wr_en        = 1'b1;
        wr_dat       = rdv;
        wr_dat[bsel] = status_flags_r[FL_T];
      end
      OP_FLAG_SET:   begin fl_we = 1'b1; fl[bsel] = 1'b1; end
      OP_FLAG_CLEAR: begin fl_we = 1'b1; fl[bsel] = 1'b0; end
      default:       wr_en = 1'b0;
    endcase
  end

  // register file carries data only, so it needs no reset
  always_ff @(posedge ref_clk)
  begin
    if (adv && wr_en)
      regs_r[wr_idx] <= wr_dat;
    if (adv && pw_en)
    begin
      regs_r[{pw_idx, 1'b0}] <= pw_dat[7:0];
      regs_r[{pw_idx, 1'b1}] <= pw_dat[15:8];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      phase_r <= PH_IDLE;
      step_r  <= 2'h0;
      ir_r    <= 16'h0000;
      imm_r   <= 16'h0000;
    end
    else
    begin
      if (!busy && go)
      begin
        ir_r  <= instr_word;
        imm_r <= instr_imm;
      end
      phase_r <= (go && !fin) ? PH_RUN : PH_IDLE;
      step_r  <= fin ? 2'h0 : (adv ? stp + 2'h1 : stp);
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      nvm_seen_r <= 1'b0;
    else
      nvm_seen_r <= stall;
  end

  assign fl_wv = be_merge({24'h000000, status_flags_r}, avs_writedata,
                          avs_byteenable);
  assign pc_wv = be_merge({16'h0000, pc_r}, avs_writedata, avs_byteenable);
  assign sp_wv = be_merge({16'h0000, sp_r}, avs_writedata, avs_byteenable);

  // software writes lose to an instruction touching the same state
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      status_flags_r <= FLAGS_RESET;
      pc_r           <= PC_RESET;
      sp_r           <= SP_RESET;
      run_r          <= 1'b0;
    end
    else
    begin
      if (adv && fl_we)
        status_flags_r <= fl;
      else if (av_ack && avs_write && avs_address[4:2] == REG_FLAGS)
        status_flags_r <= fl_wv[7:0];
      if (fin && taken)
        pc_r <= pc_r + immv + 16'h0001;
      else if (fin)
        pc_r <= pc_r + ((op == OP_LOAD_DIRECT || op == OP_STORE_DIRECT)
                        ? 16'h0002 : 16'h0001);
      else if (av_ack && avs_write && avs_address[4:2] == REG_PC)
        pc_r <= pc_wv[15:0];
      if (adv && sp_we)
        sp_r <= sp_nxt;
      else if (av_ack && avs_write && avs_address[4:2] == REG_SP)
        sp_r <= sp_wv[15:0];
      if (av_ack && avs_write && avs_address[4:2] == REG_CTRL
          && avs_byteenable[0])
        run_r <= avs_writedata[CTRL_RUN_BIT];
    end
  end

  assign av_req          = avs_read | avs_write;
  assign avs_waitrequest = av_req & ~ack_r;
  assign av_ack          = av_req & ack_r;
  assign avs_readdata    = avs_readdata_r;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ack_r          <= 1'b0;
      avs_readdata_r <= 32'h00000000;
    end
    else
    begin
      ack_r <= av_req & ~ack_r;
      if (avs_read && !ack_r)
        case (avs_address[4:2])
          REG_CTRL:  avs_readdata_r <= {31'h0, run_r};
          REG_FLAGS: avs_readdata_r <= {24'h000000, status_flags_r};
          REG_PC:    avs_readdata_r <= {16'h0000, pc_r};
          REG_SP:    avs_readdata_r <= {16'h0000, sp_r};
          REG_STATE: avs_readdata_r <= {28'h0000000, nvm_seen_r, step_r,
                                        busy};
          default:   avs_readdata_r <= 32'h00000000;
        endcase
    end
  end

  default clocking cb_core @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_two_cycles;
    busy ##1 !busy;
  endsequence

  chk_ovf_branch: assert property (
    (!busy && go && op == OP_BR_OVF_SET && status_flags_r[FL_V])
    |=> s_two_cycles)
    else $error("taken overflow branch not two cycles");
  chk_irq_skip: assert property (
    (!busy && go && op == OP_BR_IRQ_ON && !status_flags_r[FL_I])
    |=> !busy && pc_r == $past(pc_r) + 16'h0001)
    else $error("untaken irq branch wrong");
  chk_direct_load: assert property (
    (!busy && go && op == OP_LOAD_DIRECT && instr_imm < NVM_BASE)
    |=> busy ##1 (busy && dmem_re) ##1 !busy)
    else $error("direct load not three cycles");
  chk_ptr_store: assert property (
    (!busy && go && op == OP_STORE_PTR && !nvm) |-> dmem_we ##1 !busy)
    else $error("pointer store not one cycle");
  chk_pop_len: assert property (
    (!busy && go && op == OP_POP)
    |=> busy && sp_r == $past(sp_r) + 16'h0001)
    else $error("pop did not bump stack first");
  chk_left_carry: assert property (
    (fin && op == OP_SHIFT_LEFT)
    |=> status_flags_r[FL_C] == $past(rdv[7]))
    else $error("left shift carry wrong");
  chk_right_neg: assert property (
    (fin && op == OP_SHIFT_RIGHT) |=> !status_flags_r[FL_N])
    else $error("logical right shift left N set");
  chk_bit_set_io: assert property (
    (go && op == OP_IO_BIT_SET) |-> io_we && io_wdata[bsel])
    else $error("io bit set did not set bit");
  chk_t_only: assert property (
    (fin && op == OP_BIT_TO_T)
    |=> (status_flags_r & 8'hBF) == ($past(status_flags_r) & 8'hBF))
    else $error("bit store touched other flags");
  chk_slow_extra: assert property (
    (acc && nvm && !nvm_seen_r) |-> !adv && !dmem_re && !dmem_we)
    else $error("slow access finished without extra cycle");
endmodule : core_instruction_subset_exec

// ==== data_space_model.sv ====
`timescale 1ns/1ps
module data_space_model
(
  // clock
  input  wire logic        ref_clk,
  // data memory
  input  wire logic [15:0] dmem_addr,
  input  wire logic [7:0]  dmem_wdata,
  input  wire logic        dmem_re,
  input  wire logic        dmem_we,
  output logic [7:0]       dmem_rdata,
  output logic             dmem_wait,
  // program memory
  input  wire logic [15:0] pmem_addr,
  input  wire logic        pmem_re,
  output logic [7:0]       pmem_rdata,
  // io space
  input  wire logic [5:0]  io_addr,
  input  wire logic        io_re,
  input  wire logic        io_we,
  input  wire logic [7:0]  io_wdata,
  output logic [7:0]       io_rdata
);
  logic [7:0] mem [256];
  logic [7:0] io_mem [64];
  logic [1:0] slow_cnt_r = 2'h0;
  logic       slow;
  assign slow = (dmem_re | dmem_we) & dmem_addr[15];
  // slow side stalls two cycles per access
  assign dmem_wait = slow & (slow_cnt_r != 2'h2);
  // released lines show inverted data so stale values never match
  assign dmem_rdata = dmem_re ? mem[dmem_addr[7:0]] : ~mem[dmem_addr[7:0]];
  assign pmem_rdata = pmem_re ? pmem_addr[7:0] ^ 8'h3C : ~pmem_addr[7:0];
  assign io_rdata = io_re ? io_mem[io_addr] : ~io_mem[io_addr];
  always_ff @(posedge ref_clk)
  begin
    if (!slow)
      slow_cnt_r <= 2'h0;
    else if (dmem_wait)
      slow_cnt_r <= slow_cnt_r + 2'h1;
    if (dmem_we && !dmem_wait)
      mem[dmem_addr[7:0]] <= dmem_wdata;
    if (io_we)
      io_mem[io_addr] <= io_wdata;
  end
endmodule : data_space_model

// ==== core_instruction_subset_exec_bench.sv ====
`timescale 1ns/1ps
module core_instruction_subset_exec_bench;
  import exec_pkg::*;
  logic        ref_clk, rstn, instr_valid, instr_ready, dmem_re, dmem_we;
  logic        dmem_wait, pmem_re, io_re, io_we, avs_read, avs_write;
  logic        avs_waitrequest;
  logic [15:0] instr_word, instr_imm, pc, dmem_addr, pmem_addr, pc0;
  logic [7:0]  dmem_wdata, dmem_rdata, pmem_rdata, io_wdata, io_rdata;
  logic [5:0]  io_addr;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd_val;
  logic [3:0]  avs_byteenable;
  int          errors, samples_checked;

  core_instruction_subset_exec core_instruction_subset_exec_i (
    .ref_clk(ref_clk), .rstn(rstn), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_imm(instr_imm),
    .instr_ready(instr_ready), .pc(pc), .dmem_addr(dmem_addr),
    .dmem_wdata(dmem_wdata), .dmem_re(dmem_re), .dmem_we(dmem_we),
    .dmem_rdata(dmem_rdata), .dmem_wait(dmem_wait), .pmem_addr(pmem_addr),
    .pmem_re(pmem_re), .pmem_rdata(pmem_rdata), .io_addr(io_addr),
    .io_re(io_re), .io_we(io_we), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  data_space_model data_space_model_i (
    .ref_clk(ref_clk), .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata),
    .dmem_re(dmem_re), .dmem_we(dmem_we), .dmem_rdata(dmem_rdata),
    .dmem_wait(dmem_wait), .pmem_addr(pmem_addr), .pmem_re(pmem_re),
    .pmem_rdata(pmem_rdata), .io_addr(io_addr), .io_re(io_re),
    .io_we(io_we), .io_wdata(io_wdata), .io_rdata(io_rdata));

  always #2 ref_clk = ~ref_clk;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    if (got !== exp)
      errors++;
  endtask : check

  task automatic close_out;
    $display("errors %0d, checks %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  // bounded wait, sampled at the rising edge, for bus answer or idle core
  task automatic hold(input logic on_bus);
    int n;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while ((on_bus ? avs_waitrequest : !instr_ready) !== 1'b0 && n < 60);
    if ((on_bus ? avs_waitrequest : !instr_ready) !== 1'b0)
    begin
      errors++;
      close_out();
    end
  endtask : hold

  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    hold(1'b1);
    rd_val = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic exec(input logic [5:0] op, input logic [4:0] rd,
                      input logic [4:0] aux, input logic [15:0] imm);
    @(posedge ref_clk);
    instr_valid <= 1'b1;
    instr_word <= {op, rd, aux};
    instr_imm <= imm;
    hold(1'b0);
    instr_valid <= 1'b0;
  endtask : exec

  initial
  begin
    {ref_clk, rstn, instr_valid, avs_read, avs_write} = 5'h00;
    {instr_word, instr_imm, avs_address, avs_writedata} = '0;
    avs_byteenable = 4'hF;
    errors = 0;
    samples_checked = 0;
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    bus(1'b0, 5'h0C, 32'h0);
    check(rd_val, {16'h0, SP_RESET});
    bus(1'b0, 5'h14, 32'h0);
    check(rd_val, 32'h0);
    bus(1'b1, 5'h00, 32'h1);
    for (int i = 0; i < 8; i++)
      exec(OP_FLAG_SET, 5'h00, 5'(i), 16'h0);
    exec(OP_FLAG_CLEAR, 5'h00, 5'(FL_V), 16'h0);
    bus(1'b0, 5'h04, 32'h0);
    check(rd_val, 32'hF7);
    for (int i = 0; i < 8; i++)
      exec(OP_FLAG_CLEAR, 5'h00, 5'(i), 16'h0);
    hold(1'b0);
    pc0 = pc;
    exec(OP_BR_OVF_SET, 5'h00, 5'h00, 16'h0005);
    exec(OP_BR_IRQ_OFF, 5'h00, 5'h00, 16'hFFFD);
    exec(OP_BR_IRQ_ON, 5'h00, 5'h00, 16'h0009);
    exec(OP_FLAG_SET, 5'h00, 5'(FL_V), 16'h0);
    exec(OP_BR_OVF_SET, 5'h00, 5'h00, 16'h0005);
    hold(1'b0);
    check({16'h0, pc}, {16'h0, pc0 + 16'h0007});
    exec(OP_LOAD_IMM, 5'h1A, 5'h00, 16'h0010);
    exec(OP_LOAD_IMM, 5'h1B, 5'h00, 16'h0000);
    exec(OP_LOAD_IMM, 5'h05, 5'h00, 16'h00A5);
    exec(OP_LOAD_IMM, 5'h08, 5'h00, 16'h00A5);
    exec(OP_STORE_PTR, 5'h05, {PM_POSTINC, 1'b0, PTR_X}, 16'h0);
    exec(OP_LOAD_PTR, 5'h09, {PM_PREDEC, 1'b0, PTR_X}, 16'h0);
    exec(OP_STORE_DIRECT, 5'h09, 5'h09, 16'h0040);
    exec(OP_STORE_DIRECT, 5'h09, 5'h09, 16'h8001);
    exec(OP_LOAD_IMM, 5'h0A, 5'h00, 16'h0081);
    exec(OP_FLAG_CLEAR, 5'h00, 5'(FL_V), 16'h0);
    exec(OP_SHIFT_LEFT, 5'h0A, 5'h00, 16'h0);
    exec(OP_IO_OUT, 5'h0A, 5'h00, 16'h0005);
    bus(1'b0, 5'h04, 32'h0);
    check(rd_val, 32'h09);
    exec(OP_ROTATE_RIGHT, 5'h0A, 5'h00, 16'h0);
    exec(OP_IO_OUT, 5'h0A, 5'h00, 16'h0006);
    exec(OP_IO_BIT_SET, 5'h00, 5'h00, 16'h0005);
    hold(1'b0);
    bus(1'b0, 5'h04, 32'h0);
    check(rd_val, 32'h0C);
    exec(OP_LOAD_DIRECT, 5'h0B, 5'h00, 16'h0040);
    exec(OP_PUSH, 5'h00, 5'h0B, 16'h0);
    exec(OP_POP, 5'h0C, 5'h00, 16'h0);
    exec(OP_BIT_TO_T, 5'h00, 5'h08, 16'h0);
    exec(OP_T_TO_BIT, 5'h0A, 5'h01, 16'h0);
    exec(OP_LOAD_IMM, 5'h1E, 5'h00, 16'h0012);
    exec(OP_LOAD_IMM, 5'h1F, 5'h00, 16'h0000);
    exec(OP_LOAD_IMM, 5'h10, 5'h00, 16'h005A);
    exec(OP_PMEM_LOAD, 5'h0D, 5'h02, 16'h0);
    exec(OP_STORE_DISPL, 5'h00, 5'h0A, 16'h0004);
    exec(OP_LOAD_DISPLACED, 5'h0E, 5'h02, 16'h0004);
    exec(OP_STORE_PTR, 5'h00, {PM_PREDEC, 1'b0, PTR_X}, 16'h0);
    exec(OP_LOAD_PTR, 5'h0F, {PM_POSTINC, 1'b0, PTR_X}, 16'h0);
    exec(OP_SHIFT_RIGHT, 5'h0A, 5'h00, 16'h0);
    for (int i = 0; i < 5; i++)
      exec(OP_IO_OUT, 5'(11 + i), 5'h00, 16'(7 + i));
    bus(1'b0, 5'h04, 32'h0);
    check(rd_val, 32'h49);
    bus(1'b0, 5'h0C, 32'h0);
    check(rd_val, {16'h0, SP_RESET});
    check(data_space_model_i.io_mem[7], 8'hA5);
    check(data_space_model_i.io_mem[8], 8'hA5);
    check(data_space_model_i.io_mem[9], 8'h2E);
    check(data_space_model_i.io_mem[10], 8'h83);
    check(data_space_model_i.io_mem[11], 8'h5A);
    check(data_space_model_i.mem[8'h0F], 8'h5A);
    check(data_space_model_i.mem[8'h17], 8'h83);
    check(data_space_model_i.mem[8'h10], 8'hA5);
    check(data_space_model_i.mem[8'h40], 8'hA5);
    check(data_space_model_i.mem[8'h01], 8'hA5);
    check(data_space_model_i.io_mem[6], 8'h81);
    check(data_space_model_i.io_mem[5], 8'h03);
    close_out();
  end
endmodule : core_instruction_subset_exec_bench
